// [rtl/tal_pkg.sv]
package tal_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int BUS_TIMEOUT_MS = 25;
	localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int TMO_W = 20;
	localparam int CONV_CYC_DEFAULT = 1000;

	// ------------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------------
	localparam logic [7:0] IDX_LOC_VAL = 8'h00;
	localparam logic [7:0] IDX_REM_VAL = 8'h01;
	localparam logic [7:0] IDX_STATUS = 8'h02;
	localparam logic [7:0] IDX_PINS = 8'h03;
	localparam logic [7:0] IDX_CONFIG = 8'h09;
	localparam logic [7:0] IDX_LOC_HI = 8'h0b;
	localparam logic [7:0] IDX_LOC_LO = 8'h0c;
	localparam logic [7:0] IDX_REM_HI = 8'h0d;
	localparam logic [7:0] IDX_REM_LO = 8'h0e;
	localparam logic [7:0] IDX_ONESHOT = 8'h0f;
	localparam logic [7:0] IDX_REM_TRIP = 8'h19;
	localparam logic [7:0] IDX_LOC_TRIP = 8'h20;
	localparam logic [7:0] IDX_HYST = 8'h21;
	localparam logic [7:0] IDX_CONSEC = 8'h22;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_LOC_HI = 8'h55;
	localparam logic [7:0] RST_LOC_LO = 8'h00;
	localparam logic [7:0] RST_REM_HI = 8'h55;
	localparam logic [7:0] RST_REM_LO = 8'h00;
	localparam logic [7:0] RST_REM_TRIP = 8'h6c;
	localparam logic [7:0] RST_LOC_TRIP = 8'h55;
	localparam logic [7:0] RST_HYST = 8'h0a;
	localparam logic [7:0] RST_CONSEC = 8'h01;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CFG_MASK_BIT = 7;
	localparam int CFG_STANDBY_BIT = 6;
	localparam int CFG_PIN_MODE_BIT = 5;
	localparam int CONSEC_TMO_BIT = 7;
	localparam int ST_OPEN_BIT = 2;
	localparam int ST_TRIP_BIT = 1;
	localparam int ST_BUSY_BIT = 0;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [0:0] {
		TAL_CV_IDLE = 1'b0,
		TAL_CV_RUN = 1'b1
	} tal_conv_t;

endpackage : tal_pkg

// [rtl/tal_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module tal_sync
	import tal_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} tal_sync_t;

	tal_sync_t st_reg;
	tal_sync_t st_next;

	// A bit changes only once the second and third stages agree.
	always_comb begin
		st_next = st_reg;
		st_next.s1 = d_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.q[i] = st_reg.s3[i];
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_out = st_reg.q;
endmodule : tal_sync
`default_nettype wire

// [rtl/tal_trip.sv]
`timescale 1ns/1ps
`default_nettype none
module tal_trip
	import tal_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic eval_in,
	input wire logic [7:0] temp_in,
	input wire logic [7:0] limit_in,
	input wire logic [7:0] hyst_in,
	output logic trip_out
);
	typedef struct packed {
		logic trip;
	} tal_trip_t;

	tal_trip_t st_reg;
	tal_trip_t st_next;
	logic [8:0] temp_plus_hyst;

	assign temp_plus_hyst = {1'b0, temp_in} + {1'b0, hyst_in};

	// Set above the limit; release at or below limit minus hysteresis.
	always_comb begin
		st_next = st_reg;
		if (eval_in) begin
			if (temp_in > limit_in) begin
				st_next.trip = 1'b1;
			end else if (temp_plus_hyst <= {1'b0, limit_in}) begin
				st_next.trip = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign trip_out = st_reg.trip;
endmodule : tal_trip
`default_nettype wire

// [rtl/tal_alarm.sv]
// Notes on behaviour
// [RULE1] Alarm pin low on limit violation or open.
// [RULE2] Alarm pin only pulls low or releases.
// [RULE3] Alarmed device answers alert address with address.
// [RULE4] Lost arbitration on alert address means unanswered.
// [RULE5] Release alarm after answer, condition gone, status clear.
// [RULE6] Host repeats alert reads while line low.
// [RULE7] Standby stops and aborts conversion, no result.
// [RULE8] One-shot write in standby runs one conversion.
// [RULE9] New limits alarm against stored results.
// [RULE10] Open comparator sampled at conversion start.
// [RULE11] Alarm above high limit or below low.
// [RULE12] Alarm maskable; fail-safe trip never masked.
// [RULE13] Trip above limit, release at limit minus hysteresis.
// [RULE14] Shared hysteresis, one degree steps, default ten.
// [RULE15] Software sets trip limits at or above high.
// [RULE16] Shared pin selects alarm or second trip.
// [RULE17] Second trip uses high limits, hysteresis, no mask.
// [RULE18] Status latches flags; read clears ended ones.
// [RULE19] Trips pull low only, evaluated per conversion.
// [RULE20] Consecutive register resets 0x01; top bit enables timeout.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tal_alarm
	import tal_pkg::*;
#(
	parameter int AW = 12,
	parameter logic [6:0] DEV_ADDR = 7'h4c,
	parameter int CONV_CYCLES = CONV_CYC_DEFAULT,
	parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [AW-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [AW-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [7:0] adc_loc_in,
	input wire logic [7:0] adc_rem_in,
	input wire logic open_sense_in,
	input wire logic smb_clk_in,
	input wire logic ara_done_in,
	input wire logic ara_arb_lost_in,
	output logic ara_respond_out,
	output logic [7:0] ara_addr_out,
	output logic smb_timeout_out,
	input wire logic alert_pin_in,
	output logic alert_pin_out,
	output logic alert_pin_oe_n_out,
	input wire logic failsafe_trip_n_in,
	output logic failsafe_trip_n_out,
	output logic failsafe_trip_n_oe_n_out
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic wr_rdy;
		logic bvalid;
		logic [1:0] bresp;
		logic rd_rdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic [7:0] cfg;
		logic [7:0] loc_hi;
		logic [7:0] loc_lo;
		logic [7:0] rem_hi;
		logic [7:0] rem_lo;
		logic [7:0] loc_trip;
		logic [7:0] rem_trip;
		logic [7:0] hyst;
		logic [7:0] consec;
		logic [7:0] loc_val;
		logic [7:0] rem_val;
		logic [4:0] flags;
		logic open_now;
		logic alert;
		logic oneshot;
		tal_conv_t conv;
		logic [15:0] cnt;
		logic [TMO_W-1:0] tmo_cnt;
		logic tmo;
		logic scl_prev;
		logic pin_oe_n;
		logic trip_oe_n;
		logic [7:0] ara_addr;
	} tal_alarm_t;

	tal_alarm_t st_reg;
	tal_alarm_t st_next;

	logic [3:0] sync_q;
	logic scl_s;
	logic open_s;
	logic [3:0] trips;
	logic conv_done;
	logic [4:0] cond;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic wr_go;
	logic rd_go;
	logic [7:0] status_view;
	logic mode_trip2;

	// ------------------------------------------------------------------
	// Pin synchronisers and trip comparators
	// ------------------------------------------------------------------
	tal_sync #(
		.W(4)
	) u_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.d_in({open_sense_in, failsafe_trip_n_in, alert_pin_in, smb_clk_in}),
		.q_out(sync_q)
	);
	assign scl_s = sync_q[0];
	assign open_s = sync_q[3];

	// Instances 0/1 drive the fail-safe trip, 2/3 the second trip.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_trip
			logic [7:0] lim;
			assign lim = (g == 0) ? st_reg.loc_trip :
				(g == 1) ? st_reg.rem_trip :
				(g == 2) ? st_reg.loc_hi : st_reg.rem_hi;
			tal_trip u_trip (
				.mclk_in(mclk_in),
				.rst_in(rst_in),
				.eval_in(conv_done), // [RULE19]
				.temp_in((g % 2 == 0) ? adc_loc_in : adc_rem_in),
				.limit_in(lim), // [RULE13] [RULE17]
				.hyst_in(st_reg.hyst), // [RULE14]
				.trip_out(trips[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Decode and conditions
	// ------------------------------------------------------------------
	assign wr_idx = s_axi_awaddr_in[9:2];
	assign rd_idx = s_axi_araddr_in[9:2];
	assign wr_go = st_reg.wr_rdy;
	assign rd_go = st_reg.rd_rdy;
	assign mode_trip2 = st_reg.cfg[CFG_PIN_MODE_BIT];
	assign conv_done = (st_reg.conv == TAL_CV_RUN) &&
		(st_reg.cnt == 16'(CONV_CYCLES - 1)) &&
		!(st_reg.cfg[CFG_STANDBY_BIT] && !st_reg.oneshot);

	// Stored results against live limits, so new limits act at once.
	assign cond = {st_reg.loc_val > st_reg.loc_hi, // [RULE9] [RULE11]
		st_reg.loc_val < st_reg.loc_lo,
		st_reg.rem_val > st_reg.rem_hi,
		st_reg.rem_val < st_reg.rem_lo,
		st_reg.open_now}; // [RULE10]

	assign status_view = {1'b0, st_reg.flags, !st_reg.trip_oe_n,
		st_reg.conv == TAL_CV_RUN};

	function automatic logic mapped(input logic [7:0] idx);
		case (idx)
			IDX_LOC_VAL, IDX_REM_VAL, IDX_STATUS, IDX_PINS, IDX_CONFIG,
			IDX_LOC_HI, IDX_LOC_LO, IDX_REM_HI, IDX_REM_LO, IDX_ONESHOT,
			IDX_REM_TRIP, IDX_LOC_TRIP, IDX_HYST, IDX_CONSEC: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.scl_prev = scl_s;

		// Write channel: address and data are taken together.
		st_next.wr_rdy = s_axi_awvalid_in && s_axi_wvalid_in &&
			!st_reg.wr_rdy && !st_reg.bvalid;
		if (st_reg.bvalid && s_axi_bready_in) begin
			st_next.bvalid = 1'b0;
		end
		if (wr_go) begin
			st_next.bvalid = 1'b1;
			st_next.bresp = mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
			if (wr_idx == IDX_ONESHOT) begin
				st_next.oneshot = st_reg.cfg[CFG_STANDBY_BIT]; // [RULE8]
			end else if (s_axi_wstrb_in[0]) begin
				case (wr_idx)
					IDX_CONFIG: st_next.cfg = s_axi_wdata_in[7:0];
					IDX_LOC_HI: st_next.loc_hi = s_axi_wdata_in[7:0];
					IDX_LOC_LO: st_next.loc_lo = s_axi_wdata_in[7:0];
					IDX_REM_HI: st_next.rem_hi = s_axi_wdata_in[7:0];
					IDX_REM_LO: st_next.rem_lo = s_axi_wdata_in[7:0];
					IDX_REM_TRIP: st_next.rem_trip = s_axi_wdata_in[7:0];
					IDX_LOC_TRIP: st_next.loc_trip = s_axi_wdata_in[7:0];
					IDX_HYST: st_next.hyst = s_axi_wdata_in[7:0]; // [RULE14]
					IDX_CONSEC: st_next.consec = s_axi_wdata_in[7:0];
					default: st_next.bresp = st_next.bresp;
				endcase
			end
		end

		// Read channel.
		st_next.rd_rdy = s_axi_arvalid_in && !st_reg.rd_rdy && !st_reg.rvalid;
		if (st_reg.rvalid && s_axi_rready_in) begin
			st_next.rvalid = 1'b0;
		end
		if (rd_go) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
			case (rd_idx)
				IDX_LOC_VAL: st_next.rdata = st_reg.loc_val;
				IDX_REM_VAL: st_next.rdata = st_reg.rem_val;
				IDX_STATUS: st_next.rdata = status_view;
				IDX_PINS: st_next.rdata = {4'h0, sync_q[2:0], st_reg.tmo};
				IDX_CONFIG: st_next.rdata = st_reg.cfg;
				IDX_LOC_HI: st_next.rdata = st_reg.loc_hi;
				IDX_LOC_LO: st_next.rdata = st_reg.loc_lo;
				IDX_REM_HI: st_next.rdata = st_reg.rem_hi;
				IDX_REM_LO: st_next.rdata = st_reg.rem_lo;
				IDX_REM_TRIP: st_next.rdata = st_reg.rem_trip;
				IDX_LOC_TRIP: st_next.rdata = st_reg.loc_trip;
				IDX_HYST: st_next.rdata = st_reg.hyst;
				IDX_CONSEC: st_next.rdata = st_reg.consec;
				default: st_next.rdata = 8'h00;
			endcase
		end

		// Status flags: a read drops ended flags, a live condition wins.
		if (rd_go && rd_idx == IDX_STATUS) begin
			st_next.flags = cond; // [RULE18]
		end else begin
			st_next.flags = st_reg.flags | cond; // [RULE18]
		end

		// Conversion sequencer.
		case (st_reg.conv)
			TAL_CV_IDLE: begin
				st_next.cnt = 16'h0000;
				if (!st_reg.cfg[CFG_STANDBY_BIT] || st_reg.oneshot) begin
					st_next.conv = TAL_CV_RUN;
					st_next.open_now = open_s; // [RULE10]
				end
			end
			TAL_CV_RUN: begin
				st_next.cnt = st_reg.cnt + 16'h0001;
				if (st_reg.cfg[CFG_STANDBY_BIT] && !st_reg.oneshot) begin
					st_next.conv = TAL_CV_IDLE; // [RULE7]
				end else if (conv_done) begin
					st_next.conv = TAL_CV_IDLE;
					st_next.loc_val = adc_loc_in;
					st_next.rem_val = adc_rem_in;
					st_next.oneshot = (wr_go && wr_idx == IDX_ONESHOT) ?
						st_next.oneshot : 1'b0; // [RULE8]
				end
			end
			default: st_next.conv = TAL_CV_IDLE;
		endcase

		// Alarm latch and its release after the alert address answer.
		if (!st_reg.alert) begin
			st_next.alert = (|st_reg.flags) && !mode_trip2 &&
				!st_reg.cfg[CFG_MASK_BIT]; // [RULE1] [RULE12]
		end else if (ara_done_in && !ara_arb_lost_in && // [RULE4]
			st_reg.flags == 5'h00 && cond == 5'h00) begin
			st_next.alert = 1'b0; // [RULE5]
		end
		st_next.pin_oe_n = mode_trip2 ? !(trips[2] || trips[3]) : // [RULE16]
			!st_reg.alert; // [RULE2]
		st_next.trip_oe_n = !(trips[0] || trips[1]); // [RULE12] [RULE19]

		// Bus inactivity timeout, counted from the last clock edge.
		st_next.tmo = 1'b0;
		if (scl_s != st_reg.scl_prev || !st_reg.consec[CONSEC_TMO_BIT]) begin
			st_next.tmo_cnt = '0;
		end else if (st_reg.tmo_cnt == TMO_W'(TIMEOUT_CYCLES - 1)) begin
			st_next.tmo = 1'b1; // [RULE20]
			st_next.tmo_cnt = '0;
		end else begin
			st_next.tmo_cnt = st_reg.tmo_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			st_reg <= '0;
			st_reg.cfg <= RST_CONFIG;
			st_reg.loc_hi <= RST_LOC_HI;
			st_reg.loc_lo <= RST_LOC_LO;
			st_reg.rem_hi <= RST_REM_HI;
			st_reg.rem_lo <= RST_REM_LO;
			st_reg.loc_trip <= RST_LOC_TRIP;
			st_reg.rem_trip <= RST_REM_TRIP;
			st_reg.hyst <= RST_HYST; // [RULE14]
			st_reg.consec <= RST_CONSEC; // [RULE20]
			st_reg.conv <= TAL_CV_IDLE;
			st_reg.pin_oe_n <= 1'b1;
			st_reg.trip_oe_n <= 1'b1;
			st_reg.ara_addr <= {DEV_ADDR, 1'b1}; // [RULE3]
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign s_axi_awready_out = st_reg.wr_rdy;
	assign s_axi_wready_out = st_reg.wr_rdy;
	assign s_axi_bvalid_out = st_reg.bvalid;
	assign s_axi_bresp_out = st_reg.bresp;
	assign s_axi_arready_out = st_reg.rd_rdy;
	assign s_axi_rvalid_out = st_reg.rvalid;
	assign s_axi_rresp_out = st_reg.rresp;
	assign s_axi_rdata_out = {24'h000000, st_reg.rdata};
	assign ara_respond_out = st_reg.alert; // [RULE3]
	assign ara_addr_out = st_reg.ara_addr;
	assign smb_timeout_out = st_reg.tmo;
	assign alert_pin_out = 1'b0; // [RULE2]
	assign alert_pin_oe_n_out = st_reg.pin_oe_n;
	assign failsafe_trip_n_out = 1'b0; // [RULE19]
	assign failsafe_trip_n_oe_n_out = st_reg.trip_oe_n;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	a_alert_sets: assert property ((|st_reg.flags) && !mode_trip2 && // [RULE1]
		!st_reg.cfg[CFG_MASK_BIT] |=> st_reg.alert)
		else $error("alarm not raised on latched flag");
	a_pin_follows_alert: assert property (!mode_trip2 && st_reg.alert // [RULE2]
		&& !$past(mode_trip2) |=> !alert_pin_oe_n_out)
		else $error("alarm pin not pulled low");
	a_ara_matches_pin: assert property (!$past(mode_trip2) |-> // [RULE3]
		alert_pin_oe_n_out == !$past(ara_respond_out))
		else $error("alert answer flag and pin disagree");
	a_arb_lost_hold: assert property (st_reg.alert && ara_arb_lost_in // [RULE4]
		|=> st_reg.alert)
		else $error("alarm released after lost arbitration");
	a_alert_release: assert property (st_reg.alert && !ara_done_in // [RULE5]
		|=> st_reg.alert)
		else $error("alarm released without answer");
	a_standby_abort: assert property (st_reg.conv == TAL_CV_RUN && // [RULE7]
		st_reg.cfg[CFG_STANDBY_BIT] && !st_reg.oneshot
		|=> st_reg.conv == TAL_CV_IDLE && $stable(st_reg.loc_val))
		else $error("standby did not abort conversion");
	a_oneshot_run: assert property (st_reg.conv == TAL_CV_IDLE && // [RULE8]
		st_reg.oneshot |=> st_reg.conv == TAL_CV_RUN)
		else $error("one-shot did not start conversion");
	a_limit_flag: assert property (cond[4] |=> st_reg.flags[4]) // [RULE11]
		else $error("local high violation not flagged");
	a_open_flag: assert property (st_reg.conv == TAL_CV_IDLE && // [RULE10]
		!st_reg.cfg[CFG_STANDBY_BIT] && open_s |=> ##1 st_reg.flags[0])
		else $error("open sensor not flagged");
	a_mask_holds: assert property (!st_reg.alert && // [RULE12]
		st_reg.cfg[CFG_MASK_BIT] |=> !st_reg.alert)
		else $error("masked alarm asserted");
	a_trip_drive: assert property (trips[0] || trips[1] // [RULE13]
		|=> !failsafe_trip_n_oe_n_out)
		else $error("fail-safe trip not driven");
	a_trip2_drive: assert property (mode_trip2 && trips[3] // [RULE17]
		|=> !alert_pin_oe_n_out)
		else $error("second trip not driven");
	a_timeout_off: assert property (!st_reg.consec[CONSEC_TMO_BIT] // [RULE20]
		|=> !smb_timeout_out)
		else $error("timeout fired while disabled");

	c_alert: cover property (st_reg.alert ##1 !st_reg.alert);
	c_trip: cover property (!failsafe_trip_n_oe_n_out);
	c_oneshot: cover property (st_reg.oneshot && conv_done);
	c_timeout: cover property (smb_timeout_out);

endmodule : tal_alarm
`default_nettype wire

// [testbench/tal_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tal_host_model (
	input wire logic mclk_in,
	input wire logic alert_line_in,
	output logic smb_clk_out,
	output logic ara_done_out,
	output logic ara_arb_lost_out
);
	// The bus clock idles high and only runs inside a frame.
	initial begin
		smb_clk_out = 1'b1;
		ara_done_out = 1'b0;
		ara_arb_lost_out = 1'b0;
	end

	// One read of the alert response address, nine bus clocks long.
	task automatic ara(input logic lost);
		int k;
		for (k = 0; k < 18; k++) begin
			#200 smb_clk_out = ~smb_clk_out;
		end
		@(posedge mclk_in);
		ara_done_out <= 1'b1;
		ara_arb_lost_out <= lost;
		@(posedge mclk_in);
		ara_done_out <= 1'b0;
		ara_arb_lost_out <= 1'b0;
	endtask : ara

	// Repeats the alert read while the shared line stays low, at most three times.
	task automatic service(input logic lost);
		int n;
		n = 0;
		while (alert_line_in === 1'b0 && n < 3) begin
			ara(lost);
			repeat (4) @(posedge mclk_in);
			n++;
		end
	endtask : service
endmodule : tal_host_model
`default_nettype wire

// [testbench/thermal_alarm_and_trip_logic_test.sv]
`timescale 1ns/1ps
`default_nettype none
module thermal_alarm_and_trip_logic_test;
	import tal_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, open = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rdv;
	logic [1:0] bresp, rresp, rrv, brv;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] loc = 8'h20, rem = 8'h20, ara_addr;
	logic smb_clk, done, lost, respond, tmo;
	logic al_out, al_oe_n, tr_out, tr_oe_n;
	wire logic al_line = al_oe_n ? 1'b1 : al_out;
	wire logic tr_line = tr_oe_n ? 1'b1 : tr_out;
	int failures = 0, compares = 0;

	always #25 clk = ~clk;

	tal_alarm #(.CONV_CYCLES(8), .TIMEOUT_CYCLES(50)) i_tal_alarm (
		.mclk_in(clk), .rst_in(rst),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .adc_loc_in(loc), .adc_rem_in(rem),
		.open_sense_in(open), .smb_clk_in(smb_clk), .ara_done_in(done),
		.ara_arb_lost_in(lost), .ara_respond_out(respond),
		.ara_addr_out(ara_addr), .smb_timeout_out(tmo),
		.alert_pin_in(al_line), .alert_pin_out(al_out),
		.alert_pin_oe_n_out(al_oe_n), .failsafe_trip_n_in(tr_line),
		.failsafe_trip_n_out(tr_out), .failsafe_trip_n_oe_n_out(tr_oe_n)
	);

	tal_host_model i_tal_host_model (
		.mclk_in(clk), .alert_line_in(al_line), .smb_clk_out(smb_clk),
		.ara_done_out(done), .ara_arb_lost_out(lost)
	);

	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		@(posedge clk);
		awaddr <= {2'b00, i, 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk); while (bvalid !== 1'b1);
		brv = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] i);
		@(posedge clk);
		araddr <= {2'b00, i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rdv = rdata;
		rrv = rresp;
		rready <= 1'b0;
	endtask : rd

	// Long enough for one conversion plus the trip output delay.
	task automatic cv;
		repeat (30) @(posedge clk);
	endtask : cv

	// Clears stale flags, then lets the host service the alert line.
	task automatic settle;
		cv;
		rd(IDX_STATUS);
		i_tal_host_model.service(1'b0);
		chk("alert_rel", al_oe_n, 1'b1);
	endtask : settle

	task automatic t_reset;
		rd(IDX_CONFIG);
		chk("cfg_rst", rdv, 32'h00);
		rd(IDX_HYST);
		chk("hyst_rst", rdv, 32'h0a);
		rd(IDX_CONSEC);
		chk("consec_rst", rdv, 32'h01);
		rd(IDX_REM_TRIP);
		chk("rtrip_rst", rdv, 32'h6c);
		rd(8'h30);
		chk("unmapped", rrv, RESP_SLVERR);
		wr(8'h30, 8'h11);
		chk("unmapped_wr", brv, RESP_SLVERR);
		chk("pins_drive", {al_out, tr_out}, 2'b00);
		chk("alert_idle", al_oe_n, 1'b1);
	endtask : t_reset

	task automatic t_alarm;
		loc <= 8'h60;
		cv;
		chk("alert_hi", al_oe_n, 1'b0);
		chk("ara_addr", ara_addr, 8'h99);
		chk("ara_resp", respond, 1'b1);
		rd(IDX_STATUS);
		chk("st_lochi", rdv[6], 1'b1);
		i_tal_host_model.service(1'b0);
		chk("alert_live", al_oe_n, 1'b0);
		loc <= 8'h20;
		cv;
		rd(IDX_STATUS);
		i_tal_host_model.service(1'b1);
		chk("alert_lost", al_oe_n, 1'b0);
		i_tal_host_model.service(1'b0);
		chk("alert_ans", al_oe_n, 1'b1);
		chk("ara_idle", respond, 1'b0);
	endtask : t_alarm

	task automatic t_trip;
		wr(IDX_CONFIG, 8'h80);
		wr(IDX_HYST, 8'h05);
		rd(IDX_HYST);
		chk("hyst_wr", rdv, 32'h05);
		chk("bresp_ok", brv, RESP_OKAY);
		wstrb <= 4'he;
		wr(IDX_HYST, 8'h33);
		wstrb <= 4'hf;
		rd(IDX_HYST);
		chk("hyst_strb", rdv, 32'h05);
		rem <= 8'h6c;
		cv;
		chk("trip_eq", tr_oe_n, 1'b1);
		rem <= 8'h6d;
		cv;
		chk("trip_set", tr_oe_n, 1'b0);
		chk("alert_mask", al_oe_n, 1'b1);
		rd(IDX_PINS);
		chk("pins_trip", rdv, 32'h06);
		rem <= 8'h68;
		cv;
		chk("trip_hold", tr_oe_n, 1'b0);
		rem <= 8'h67;
		cv;
		chk("trip_rel", tr_oe_n, 1'b1);
		rem <= 8'h20;
		wr(IDX_CONFIG, 8'h00);
		settle;
	endtask : t_trip

	task automatic t_stby;
		wr(IDX_CONFIG, 8'h40);
		cv;
		loc <= 8'h40;
		cv;
		rd(IDX_LOC_VAL);
		chk("stby_hold", rdv, 32'h20);
		wr(IDX_ONESHOT, 8'h5a);
		cv;
		rd(IDX_LOC_VAL);
		chk("oneshot", rdv, 32'h40);
		loc <= 8'h10;
		cv;
		rd(IDX_LOC_VAL);
		chk("stby_back", rdv, 32'h40);
		wr(IDX_LOC_LO, 8'h50);
		cv;
		chk("alert_lo", al_oe_n, 1'b0);
		wr(IDX_LOC_LO, 8'h00);
		settle;
	endtask : t_stby

	task automatic t_open;
		wr(IDX_CONFIG, 8'h00);
		loc <= 8'h20;
		open <= 1'b1;
		cv;
		rd(IDX_STATUS);
		chk("st_open", rdv[2], 1'b1);
		chk("alert_open", al_oe_n, 1'b0);
		open <= 1'b0;
		cv;
		settle;
	endtask : t_open

	task automatic t_thr2;
		wr(IDX_CONFIG, 8'h20);
		loc <= 8'h60;
		cv;
		chk("trip2_set", al_oe_n, 1'b0);
		loc <= 8'h51;
		cv;
		chk("trip2_hold", al_oe_n, 1'b0);
		loc <= 8'h50;
		cv;
		chk("trip2_rel", al_oe_n, 1'b1);
		loc <= 8'h20;
		cv;
		rd(IDX_STATUS);
		wr(IDX_CONFIG, 8'h00);
	endtask : t_thr2

	task automatic t_tmo;
		int k, hit;
		hit = 0;
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			if (tmo === 1'b1) hit++;
		end
		chk("tmo_off", hit, 32'h0);
		wr(IDX_CONSEC, 8'h81);
		hit = 0;
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			if (tmo === 1'b1) hit++;
		end
		chk("tmo_on", hit, 32'h1);
		hit = 0;
		fork
			i_tal_host_model.ara(1'b0);
			for (k = 0; k < 60; k++) begin
				@(posedge clk);
				if (tmo === 1'b1) hit++;
			end
		join
		chk("tmo_busy", hit, 32'h0);
	endtask : t_tmo

	task automatic tally_and_finish;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset;
		t_alarm;
		t_trip;
		t_stby;
		t_open;
		t_thr2;
		t_tmo;
		tally_and_finish;
	end

	initial begin
		#(50 * 8000);
		failures++;
		tally_and_finish;
	end
endmodule : thermal_alarm_and_trip_logic_test
`default_nettype wire
